// ==== core/pulse_capture_pkg.sv ====
package pulse_capture_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 200_000_000;
	localparam int unsigned PERIPH_HZ       = 25_000_000;
	localparam int unsigned PERIPH_DIV      = CLK_HZ / PERIPH_HZ;
	localparam int unsigned COUNT_DIV       = 4;
	localparam int unsigned FILTER_SAMPLES  = 3;
	localparam int unsigned CNT_W           = 16;

	// ------------------------------------------------------------
	// Register map (word index = byte address / 4)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_W           = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_CTRL  = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_CAPA  = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_STAT  = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_MASK  = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_PIN   = 4'h5;

	localparam int unsigned BIT_START   = 0;
	localparam int unsigned BIT_CAPA    = 0;
	localparam int unsigned BIT_OVF     = 1;
	localparam int unsigned BIT_PIN     = 0;
	localparam int unsigned IRQ_W       = 2;

	localparam logic [IRQ_W-1:0] MASK_RESET = 2'h0;
	localparam logic [CNT_W-1:0] CNT_MAX    = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
		logic              wr;
		logic              rd;
	} bus_req_s;

endpackage

// ==== core/high_pulse_width_capture.sv ====
// Summary of operation
// - Counter steps on each peripheral clock divided by four; peripheral clock 25 MHz.
// - Normal counting mode, register A used as input capture, no channel sync.
// - Capture input triggers on rising and falling edges.
// - Each capture into register A clears the counter to zero.
// - Noise filter on capture input samples at the undivided peripheral clock.
// - Counting starts only after software writes 1 to count-start bit.
// - Qualified edge copies counter, clears it, raises capture request together.
// - Counter wrapping past maximum raises an overflow request.
// - Overflow and capture requests drive separate lines; the interrupt controller ranks overflow above capture.
// - Capture clear coinciding with wrap wins; no overflow request then.
//
// The plain strobed port and the register offsets were chosen for this implementation.
module high_pulse_width_capture
	import pulse_capture_pkg::*;
#(
	parameter int unsigned DIV      = COUNT_DIV,
	parameter int unsigned FILT_LEN = FILTER_SAMPLES
) (
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [31:0]       rdata,
	input  wire logic              capture_in_a,
	output logic                   irq,
	output logic                   capture_a_irq,
	output logic                   overflow_irq
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]          pin_sync;
		logic [7:0]          pclk_cnt;
		logic [FILT_LEN-1:0] filt_shift;
		logic                filt_level;
		logic [7:0]          div_cnt;
		logic                run;
		logic [CNT_W-1:0]    timer_counter_value;
		logic [CNT_W-1:0]    capture_reg_a;
		logic [IRQ_W-1:0]    status;
		logic [IRQ_W-1:0]    mask;
		logic [31:0]         rdata;
	} state_s;

	state_s st;
	state_s next_st;

	bus_req_s req;
	logic     pclk_tick;
	logic     cnt_tick;
	logic     edge_seen;
	logic     wrap;
	logic [IRQ_W-1:0] set_bits;

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		// Pin is asynchronous: two flops before any reader
		next_st.pin_sync = {st.pin_sync[0], capture_in_a};

		// Peripheral clock as an enable; 200 MHz / 8 = 25 MHz
		pclk_tick = (st.pclk_cnt == 8'(PERIPH_DIV - 1));
		next_st.pclk_cnt = pclk_tick ? 8'h00 : st.pclk_cnt + 8'h01;

		// Filter takes a level only after FILT_LEN equal samples
		edge_seen = 1'b0;
		if (pclk_tick) begin
			next_st.filt_shift = {st.filt_shift[FILT_LEN-2:0], st.pin_sync[1]};
			if (&next_st.filt_shift && !st.filt_level) begin
				next_st.filt_level = 1'b1;
				edge_seen = st.run;
			end else if (~|next_st.filt_shift && st.filt_level) begin
				next_st.filt_level = 1'b0;
				edge_seen = st.run;
			end
		end

		// Counter clock: peripheral clock divided by DIV
		cnt_tick = 1'b0;
		if (pclk_tick && st.run) begin
			if (st.div_cnt == 8'(DIV - 1)) begin
				next_st.div_cnt = 8'h00;
				cnt_tick = 1'b1;
			end else begin
				next_st.div_cnt = st.div_cnt + 8'h01;
			end
		end

		// Free-running normal mode, no sync with other channels
		wrap = 1'b0;
		if (edge_seen) begin
			next_st.capture_reg_a = st.timer_counter_value;
			next_st.timer_counter_value = CNT_ZERO;
			next_st.div_cnt = 8'h00;
		end else if (cnt_tick) begin
			wrap = (st.timer_counter_value == CNT_MAX);
			next_st.timer_counter_value = st.timer_counter_value + 16'h0001;
		end
		// Clear-on-capture suppresses wrap in the same cycle
		set_bits = '0;
		set_bits[BIT_CAPA] = edge_seen;
		set_bits[BIT_OVF] = wrap && !edge_seen;

		// Registers
		next_st.rdata = 32'h0000_0000;
		if (req.wr) begin
			unique case (req.addr)
				OFS_CTRL: next_st.run = req.wdata[BIT_START];
				OFS_MASK: next_st.mask = req.wdata[IRQ_W-1:0];
				default: ;
			endcase
		end
		// Write-one-to-clear; a set in the same cycle wins
		if (req.wr && req.addr == OFS_STAT)
			next_st.status = (st.status & ~req.wdata[IRQ_W-1:0]) | set_bits;
		else
			next_st.status = st.status | set_bits;
		if (req.rd) begin
			unique case (req.addr)
				OFS_CTRL:  next_st.rdata[BIT_START] = st.run;
				OFS_COUNT: next_st.rdata[CNT_W-1:0] = st.timer_counter_value;
				OFS_CAPA:  next_st.rdata[CNT_W-1:0] = st.capture_reg_a;
				OFS_STAT:  next_st.rdata[IRQ_W-1:0] = st.status;
				OFS_MASK:  next_st.rdata[IRQ_W-1:0] = st.mask;
				OFS_PIN:   next_st.rdata[BIT_PIN] = st.filt_level;
				default:   next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata = st.rdata;
	// Separate lines let the interrupt controller rank overflow above capture
	assign capture_a_irq = st.status[BIT_CAPA] & st.mask[BIT_CAPA];
	assign overflow_irq  = st.status[BIT_OVF] & st.mask[BIT_OVF];
	assign irq = capture_a_irq | overflow_irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_capture_copies: assert property (@(posedge core_clk) disable iff (!nrst)
		edge_seen |=> st.capture_reg_a == $past(st.timer_counter_value) && st.timer_counter_value == CNT_ZERO
			&& st.status[BIT_CAPA])
		else $error("capture did not copy and clear");
	a_clear_beats_wrap: assert property (@(posedge core_clk) disable iff (!nrst)
		edge_seen && !st.status[BIT_OVF] && !(req.wr && req.addr == OFS_STAT) |=> !st.status[BIT_OVF])
		else $error("overflow raised on capture clear");
	a_wrap_sets_ovf: assert property (@(posedge core_clk) disable iff (!nrst)
		cnt_tick && !edge_seen && st.timer_counter_value == CNT_MAX |=> st.status[BIT_OVF]
			&& st.timer_counter_value == CNT_ZERO)
		else $error("wrap lost");
	a_stopped_holds: assert property (@(posedge core_clk) disable iff (!nrst)
		!st.run && !edge_seen |=> st.timer_counter_value == $past(st.timer_counter_value))
		else $error("counter moved while stopped");
	a_count_spacing: assert property (@(posedge core_clk) disable iff (!nrst)
		cnt_tick |=> !cnt_tick [*8])
		else $error("count ticks too close");
	a_status_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
		st.status[BIT_CAPA] && !(req.wr && req.addr == OFS_STAT && req.wdata[BIT_CAPA])
			|=> st.status[BIT_CAPA])
		else $error("capture request lost");
	a_edge_filtered: assert property (@(posedge core_clk) disable iff (!nrst)
		edge_seen |-> pclk_tick && (&next_st.filt_shift || ~|next_st.filt_shift))
		else $error("unfiltered edge");
	a_both_edges: assert property (@(posedge core_clk) disable iff (!nrst)
		st.run && pclk_tick && (next_st.filt_level != st.filt_level) |-> edge_seen)
		else $error("edge not captured");

	// ------------------------------------------------------------
	// Timebase checks
	// ------------------------------------------------------------
	a_pclk_period: assert property (@(posedge core_clk) disable iff (!nrst)
		pclk_tick |=> !pclk_tick [*7])
		else $error("peripheral tick too early");
	a_tick_needs_run: assert property (@(posedge core_clk) disable iff (!nrst)
		cnt_tick |-> st.run && pclk_tick)
		else $error("count tick without run");
	// Wrap is checked separately, so compare modulo the counter width
	a_counter_steps: assert property (@(posedge core_clk) disable iff (!nrst)
		cnt_tick && !edge_seen |=> st.timer_counter_value == CNT_W'($past(st.timer_counter_value) + 16'h0001))
		else $error("counter did not step");
	a_no_capture_stopped: assert property (@(posedge core_clk) disable iff (!nrst)
		!st.run |-> !edge_seen)
		else $error("capture while stopped");
	a_run_write: assert property (@(posedge core_clk) disable iff (!nrst)
		req.wr && req.addr == OFS_CTRL |=> st.run == $past(req.wdata[BIT_START]))
		else $error("count start not taken");

	// ------------------------------------------------------------
	// Request flag checks
	// ------------------------------------------------------------
	a_ovf_only_wrap: assert property (@(posedge core_clk) disable iff (!nrst)
		!wrap && !st.status[BIT_OVF] |=> !st.status[BIT_OVF])
		else $error("overflow without wrap");
	a_ovf_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
		st.status[BIT_OVF] && !(req.wr && req.addr == OFS_STAT && req.wdata[BIT_OVF])
			|=> st.status[BIT_OVF])
		else $error("overflow request lost");
	a_w1c_clears: assert property (@(posedge core_clk) disable iff (!nrst)
		req.wr && req.addr == OFS_STAT && req.wdata[BIT_CAPA] && !edge_seen |=> !st.status[BIT_CAPA])
		else $error("capture request not cleared");
	a_mask_write: assert property (@(posedge core_clk) disable iff (!nrst)
		req.wr && req.addr == OFS_MASK |=> st.mask == $past(req.wdata[IRQ_W-1:0]))
		else $error("mask not taken");

	// ------------------------------------------------------------
	// Read port checks
	// ------------------------------------------------------------
	// Read data must not linger, software relies on zero when idle
	a_rdata_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		!req.rd |=> st.rdata == 32'h0000_0000)
		else $error("read data lingers");
	a_read_capa: assert property (@(posedge core_clk) disable iff (!nrst)
		req.rd && req.addr == OFS_CAPA |=> st.rdata[CNT_W-1:0] == $past(st.capture_reg_a))
		else $error("capture read wrong");

endmodule

// ==== tb/pulse_source.sv ====
module pulse_source (
	input  wire logic        core_clk,
	input  wire logic        fire,
	input  wire logic [15:0] hi_len,
	output logic             capture_in_a
);
	timeunit 1ns;
	timeprecision 1ps;
	// High for hi_len clocks after fire, low otherwise
	logic [15:0] left = 16'h0000;
	initial capture_in_a = 1'b0;
	always @(posedge core_clk) begin
		if (fire) begin
			left <= hi_len;
			capture_in_a <= 1'b1;
		end else if (left > 16'h0001) begin
			left <= left - 16'h0001;
		end else begin
			left <= 16'h0000;
			capture_in_a <= 1'b0;
		end
	end
endmodule

// ==== tb/tb.sv ====
module tb;
	import pulse_capture_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic              core_clk = 1'b0;
	logic              nrst = 1'b0;
	logic [ADDR_W-1:0] addr = 4'h0;
	logic [31:0]       wdata = 32'h0;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic              fire = 1'b0;
	logic [15:0]       hi_len = 16'h0;
	logic [31:0]       rdata;
	logic [31:0]       d;
	logic              capture_in_a;
	logic              irq;
	logic              capture_a_irq;
	logic              overflow_irq;
	int                n_fail = 0;
	int                samples_checked = 0;
	int                cycles = 0;
	logic              start_flag = 1'b0;
	int                ovf_count = 0;
	longint            width_ns = 0;
	high_pulse_width_capture dut (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .capture_in_a(capture_in_a), .irq(irq), .capture_a_irq(capture_a_irq),
		.overflow_irq(overflow_irq));
	pulse_source src (.core_clk(core_clk), .fire(fire), .hi_len(hi_len), .capture_in_a(capture_in_a));
	initial forever #2.5 core_clk = ~core_clk;
	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge core_clk) {wr, addr, wdata} <= {1'b1, a, v};
		@(posedge core_clk) wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rreg(input logic [ADDR_W-1:0] a);
		@(posedge core_clk) {rd, addr} <= {1'b1, a};
		@(posedge core_clk) rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic pulse(input logic [15:0] len, input int gap);
		@(posedge core_clk) {fire, hi_len} <= {1'b1, len};
		@(posedge core_clk) fire <= 1'b0;
		repeat (gap) @(posedge core_clk);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_hold();
		rreg(OFS_MASK); check(d, 32'h0);
		rreg(OFS_STAT); check(d, 32'h0);
		rreg(4'hF); check(d, 32'h0);
		pulse(16'd800, 900);
		rreg(OFS_COUNT); check(d, 32'h0);
		rreg(OFS_STAT); check(d, 32'h0);
	endtask
	// Software side: pin high starts, pin low ends the measurement
	task automatic t_measure();
		wreg(OFS_CTRL, 32'h1);
		pulse(16'd3200, 100);
		rreg(OFS_STAT); check(d, 32'h1);
		rreg(OFS_PIN); check(d, 32'h1);
		if (d[BIT_PIN]) begin
			start_flag = 1'b1;
			ovf_count = 0;
		end
		rreg(OFS_COUNT); check(32'(d < 32'h4), 32'h1);
		wreg(OFS_STAT, 32'h1);
		rreg(OFS_STAT); check(d, 32'h0);
		repeat (3200) @(posedge core_clk);
		rreg(OFS_STAT); check(d, 32'h1);
		if (d[BIT_OVF] && start_flag) ovf_count++;
		check(32'(ovf_count > 65535), 32'h0);
		rreg(OFS_PIN); check(d, 32'h0);
		// Filter delay is equal on both edges, leaving one tick of jitter
		rreg(OFS_CAPA); check(32'(d >= 32'd99 && d <= 32'd101), 32'h1);
		check(32'(start_flag), 32'h1);
		width_ns = 160 * (longint'(ovf_count) * 65536 + longint'(d[15:0]));
		check(32'(width_ns >= 15840 && width_ns <= 16160), 32'h1);
		start_flag = 1'b0;
	endtask
	task automatic t_irq();
		#1 check(32'(irq), 32'h0);
		wreg(OFS_MASK, 32'h1);
		#1 check(32'({irq, capture_a_irq, overflow_irq}), 32'h6);
		wreg(OFS_STAT, 32'h1);
		#1 check(32'(irq), 32'h0);
	endtask
	task automatic t_glitch();
		pulse(16'd8, 100);
		rreg(OFS_STAT); check(d, 32'h0);
	endtask
	task automatic final_report();
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset_hold();
		t_measure();
		t_irq();
		t_glitch();
		final_report();
	end
endmodule
